// [hdl/idx_add_pkg.sv]
/*
 * constants for the indexed-add cycle sequencer: word width, delay-line
 * timings and their cycle counts at the 250 mhz core clock.
 * assumes nothing beyond a synthesis tool that accepts packages.
 */
package idx_add_pkg;
    localparam int WORD_W = 12;
    localparam int CLK_PERIOD_PS = 4000;
    // ----------------------------------------------------------------
    // delay-line timings
    // ----------------------------------------------------------------
    localparam int TP2_TP3_NS = 350;
    localparam int TP3_TP4_NS = 300;
    localparam int TP4_TP5_NS = 400;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] TP2_TP3_CYC =
        CNT_W'((TP2_TP3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] TP3_TP4_CYC =
        CNT_W'((TP3_TP4_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] TP4_TP5_CYC =
        CNT_W'((TP4_TP5_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
    localparam logic [4:0] TS_RESET = 5'h01;
    // bit 00 is the msb; bit 11 the lsb
    localparam int BIT00 = WORD_W - 1;
    typedef enum logic [2:0] {
        ST_TS1, ST_TS2, ST_TS3, ST_TS4, ST_TS5
    } tstate_t;
endpackage : idx_add_pkg

// [hdl/pulse_delay.sv]
/*
 * one delay-line pulse generator: a start pulse yields one output
 * pulse a fixed number of cycles later.
 * assumes start pulses are spaced wider than the delay.
 */
`timescale 1ns/1ps
`default_nettype none
module pulse_delay
    import idx_add_pkg::*;
#(
    parameter logic [CNT_W-1:0] DELAY = 8'h01
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_start,
    output logic o_pulse
);
    logic [CNT_W-1:0] count_reg;
    logic busy_reg;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= CNT_RESET;
            busy_reg <= 1'b0;
            o_pulse <= 1'b0;
        end else begin
            o_pulse <= 1'b0;
            if (i_start) begin
                count_reg <= DELAY - 8'h01;
                busy_reg <= 1'b1;
                if (DELAY == 8'h01) begin
                    o_pulse <= 1'b1;
                    busy_reg <= 1'b0;
                end
            end else if (busy_reg) begin
                count_reg <= count_reg - 8'h01;
                if (count_reg == 8'h01) begin
                    o_pulse <= 1'b1;
                    busy_reg <= 1'b0;
                end
            end
        end
    end
endmodule : pulse_delay
`default_nettype wire

// [hdl/idx_add_seq.sv]
/*
 * time-state sequencer and datapath control for the defer tail and
 * execute cycle of the indexed-add instruction.
 * assumes core memory answers a started cycle with a read strobe and
 * later a done pulse, each one cycle wide and synchronous to i_mclk.
 */
// Functional notes
// - ts3 gates memory word onto bus
// - tp3 loads buffer with memory plus carry
// - tp3 moves ts3 to ts4
// - tp4 defer alt mode sets half-word flag
// - tp4 sets time state five
// - tp5 follows tp4 by 400 ns
// - tp5 clocks run flag, cleared by halt inhibit
// - tp5 moves ts5 to ts1
// - set-cycle-complete sets cycle-complete flag
// - ts1 defer-setting enables buffer bits 5-11
// - ts1 index defer enables buffer bits 2-4
// - tp1 only when run, idle, complete
// - tp1 loads address register from bus
// - tp1 moves ts1 to ts2
// - read strobe makes tp2, clears idle
// - tp3 follows tp2 by 350 ns
// - memory done sets idle flag
// - add decode with execute sets add control
// - ts4 add enables buffer, accumulator into adder
// - tp4 follows tp3 by 300 ns
// - tp4 add loads sum into accumulator
// - carry out of bit 00 sets overflow
// - ts3 index defer generates carry insert
// - tp1 with memory enable starts memory
`timescale 1ns/1ps
`default_nettype none
module idx_add_seq
    import idx_add_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [idx_add_pkg::WORD_W-1:0] i_mem_data,
    input wire logic i_memory_read_strobe,
    input wire logic i_mem_done,
    input wire logic i_memory_enable,
    input wire logic i_interrupt_cycle_flag,
    input wire logic i_memory_gate_inhibit,
    input wire logic i_second_execute_state,
    input wire logic i_indexed_add_instruction,
    input wire logic i_index_class,
    input wire logic i_index_op,
    input wire logic i_alt_mode,
    input wire logic i_defer_flag,
    input wire logic i_defer_set,
    input wire logic i_execute_flag,
    input wire logic i_half_word_access,
    input wire logic i_halt_inhibit,
    input wire logic i_set_cycle_complete,
    output logic o_start_memory,
    output logic [idx_add_pkg::WORD_W-1:0] o_memory_address_register,
    output logic [idx_add_pkg::WORD_W-1:0] o_memory_buffer,
    output logic [idx_add_pkg::WORD_W-1:0] o_accumulator,
    output logic [idx_add_pkg::WORD_W-1:0] o_register_bus,
    output logic o_overflow,
    output logic o_half_word,
    output logic o_run,
    output logic o_memory_idle,
    output logic o_cycle_complete,
    output logic [4:0] o_time_state,
    output logic o_accumulator_add_control
);
    import idx_add_pkg::*;

    default clocking seq_ck @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    // ----------------------------------------------------------------
    // time states and pulses
    // ----------------------------------------------------------------
    tstate_t state_reg;
    logic timing_pulse_one;
    logic timing_pulse_two;
    logic timing_pulse_three;
    logic timing_pulse_four;
    logic timing_pulse_five;
    logic time_state_one;
    logic time_state_three;
    logic time_state_four;
    logic tp1_armed_reg;
    logic carry_insert;
    logic [WORD_W-1:0] bus_next;
    logic [WORD_W:0] sum_next;
    logic [WORD_W-1:0] bus_mb_part;
    logic [WORD_W-1:0] bus_mem_part;

    assign time_state_one = (state_reg == ST_TS1);
    assign time_state_three = (state_reg == ST_TS3);
    assign time_state_four = (state_reg == ST_TS4);

    // one pulse per ts1 visit, gated by the three flags
    assign timing_pulse_one = time_state_one && tp1_armed_reg && o_run
        && o_memory_idle && o_cycle_complete;
    assign timing_pulse_two = (state_reg == ST_TS2)
        && i_memory_read_strobe;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tp1_armed_reg <= 1'b1;
        end else if (timing_pulse_one) begin
            tp1_armed_reg <= 1'b0;
        end else if (timing_pulse_five) begin
            tp1_armed_reg <= 1'b1;
        end
    end

    pulse_delay #(.DELAY(TP2_TP3_CYC)) u_tp3 (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_start(timing_pulse_two),
        .o_pulse(timing_pulse_three)
    );

    pulse_delay #(.DELAY(TP3_TP4_CYC)) u_tp4 (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_start(timing_pulse_three),
        .o_pulse(timing_pulse_four)
    );

    pulse_delay #(.DELAY(TP4_TP5_CYC)) u_tp5 (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_start(timing_pulse_four),
        .o_pulse(timing_pulse_five)
    );

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_TS1;
        end else begin
            case (state_reg)
                ST_TS1: begin
                    if (timing_pulse_one) begin
                        state_reg <= ST_TS2;
                    end
                end
                ST_TS2: begin
                    if (timing_pulse_two) begin
                        state_reg <= ST_TS3;
                    end
                end
                ST_TS3: begin
                    if (timing_pulse_three) begin
                        state_reg <= ST_TS4;
                    end
                end
                ST_TS4: begin
                    if (timing_pulse_four) begin
                        state_reg <= ST_TS5;
                    end
                end
                ST_TS5: begin
                    if (timing_pulse_five) begin
                        state_reg <= ST_TS1;
                    end
                end
                default: begin
                    state_reg <= ST_TS1;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_time_state <= TS_RESET;
        end else begin
            o_time_state <= 5'h00;
            case (state_reg)
                ST_TS1: o_time_state <= timing_pulse_one ? 5'h02 : 5'h01;
                ST_TS2: o_time_state <= timing_pulse_two ? 5'h04 : 5'h02;
                ST_TS3: o_time_state <= timing_pulse_three ? 5'h08 : 5'h04;
                ST_TS4: o_time_state <= timing_pulse_four ? 5'h10 : 5'h08;
                ST_TS5: o_time_state <= timing_pulse_five ? 5'h01 : 5'h10;
                default: o_time_state <= TS_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control flags
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_run <= 1'b1;
        end else if (timing_pulse_five) begin
            o_run <= !i_halt_inhibit;
        end
    end

    // done wins over strobe: done ends the cycle that strobe opened
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_memory_idle <= 1'b1;
        end else if (i_mem_done) begin
            o_memory_idle <= 1'b1;
        end else if (i_memory_read_strobe) begin
            o_memory_idle <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cycle_complete <= 1'b1;
        end else if (i_set_cycle_complete) begin
            o_cycle_complete <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_start_memory <= 1'b0;
        end else begin
            o_start_memory <= timing_pulse_one && i_memory_enable;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_accumulator_add_control <= 1'b0;
        end else begin
            o_accumulator_add_control <= i_indexed_add_instruction
                && i_execute_flag;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_half_word <= 1'b0;
        end else if (timing_pulse_four && i_defer_flag && i_alt_mode
                && o_memory_buffer[BIT00]) begin
            o_half_word <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // register bus and adder
    // ----------------------------------------------------------------
    assign carry_insert = time_state_three && i_defer_flag && i_index_class
        && i_index_op && !i_half_word_access;

    always_comb begin
        bus_mem_part = WORD_RESET;
        bus_mb_part = WORD_RESET;
        if (time_state_three && i_memory_enable && !i_interrupt_cycle_flag
                && !i_memory_gate_inhibit) begin
            bus_mem_part = i_mem_data;
        end
        if (time_state_one && i_defer_set && !i_defer_flag) begin
            bus_mb_part[6:0] = o_memory_buffer[6:0];
        end
        if (time_state_one && i_defer_flag && i_index_class) begin
            bus_mb_part[9:7] = o_memory_buffer[9:7];
        end
    end

    always_comb begin
        sum_next = {1'b0, WORD_RESET};
        bus_next = bus_mem_part | bus_mb_part;
        if (time_state_four && o_accumulator_add_control
                && i_execute_flag) begin
            sum_next = {1'b0, o_accumulator}
                + {1'b0, o_memory_buffer};
            bus_next = sum_next[WORD_W-1:0];
        end else if (carry_insert) begin
            sum_next = {1'b0, bus_next} + {{WORD_W{1'b0}}, 1'b1};
            bus_next = sum_next[WORD_W-1:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_register_bus <= WORD_RESET;
        end else begin
            o_register_bus <= bus_next;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_memory_address_register <= WORD_RESET;
        end else if (timing_pulse_one) begin
            o_memory_address_register <= bus_next;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_memory_buffer <= WORD_RESET;
        end else if (timing_pulse_three && !i_second_execute_state) begin
            o_memory_buffer <= bus_next;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_accumulator <= WORD_RESET;
        end else if (timing_pulse_four && o_accumulator_add_control) begin
            o_accumulator <= bus_next;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_overflow <= 1'b0;
        end else if (timing_pulse_four && o_accumulator_add_control
                && sum_next[WORD_W]) begin
            o_overflow <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    ts3_to_ts4_a: assert property (
        timing_pulse_three && time_state_three |=> time_state_four)
        else $error("tp3 did not move ts3 to ts4");
    ts4_to_ts5_a: assert property (
        timing_pulse_four && time_state_four |=> state_reg == ST_TS5)
        else $error("tp4 did not set ts5");
    tp5_delay_a: assert property (
        timing_pulse_four |-> ##100 timing_pulse_five)
        else $error("tp5 not 400 ns after tp4");
    tp3_delay_a: assert property (
        timing_pulse_two |-> ##88 timing_pulse_three)
        else $error("tp3 not 350 ns after tp2");
    tp4_delay_a: assert property (
        timing_pulse_three |-> ##75 timing_pulse_four)
        else $error("tp4 not 300 ns after tp3");
    tp1_gate_a: assert property (
        time_state_one && !(o_run && o_memory_idle && o_cycle_complete)
        |=> time_state_one)
        else $error("ts1 left without run, idle and complete");
    ts5_to_ts1_a: assert property (
        timing_pulse_five && state_reg == ST_TS5 |=> time_state_one)
        else $error("tp5 did not return to ts1");
    start_mem_a: assert property (
        timing_pulse_one && i_memory_enable |=> o_start_memory)
        else $error("memory not started at tp1");
    idle_clear_a: assert property (
        i_memory_read_strobe && !i_mem_done |=> !o_memory_idle)
        else $error("strobe did not clear idle");
    acc_load_a: assert property (
        timing_pulse_four && o_accumulator_add_control && time_state_four
        && i_execute_flag |=> o_accumulator
        == $past(o_accumulator) + $past(o_memory_buffer))
        else $error("accumulator not loaded with sum");
    full_cycle_c: cover property (
        timing_pulse_one ##[1:1000] timing_pulse_five);
    overflow_c: cover property ($rose(o_overflow));
    half_word_c: cover property ($rose(o_half_word));
endmodule : idx_add_seq
`default_nettype wire

// [tb/core_mem_model.sv]
/* core memory model: answers a start pulse with a read strobe, then done.
 * assumes o_start_memory is a one-cycle pulse on i_mclk. */
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
    input wire logic i_mclk,
    input wire logic i_start,
    input wire logic i_slow,
    input wire logic [11:0] i_word,
    output logic o_strobe,
    output logic o_done,
    output logic [11:0] o_data
);
    initial begin
        o_strobe = 1'b0;
        o_done = 1'b0;
        o_data = 12'h000;
        forever begin
            @(posedge i_mclk);
            if (i_start === 1'b1) begin
                // word not sensed yet: show a wrong value
                #1 o_data = ~i_word;
                repeat (i_slow ? 190 : 125) @(posedge i_mclk);
                #1 o_strobe = 1'b1;
                o_data = i_word;
                @(posedge i_mclk);
                #1 o_strobe = 1'b0;
                repeat (119) @(posedge i_mclk);
                #1 o_done = 1'b1;
                o_data = ~i_word;
                @(posedge i_mclk);
                #1 o_done = 1'b0;
            end
        end
    end
endmodule : core_mem_model
`default_nettype wire

// [tb/idx_add_seq_tb.sv]
/* bench for idx_add_seq: defer, add, gating, halt and memory-off cycles.
 * assumes core_mem_model stands on the memory side. */
`timescale 1ns/1ps
`default_nettype none
module idx_add_seq_tb;
    import idx_add_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic slow = 1'b0;
    logic [WORD_W-1:0] word = 12'h000;
    logic [WORD_W-1:0] mdata, ma, mb, ac, rbus;
    logic [4:0] ts;
    logic strobe, done, start, ovf, half, run, idle, cc, add_ctl;
    logic mem_en = 1'b1, inter = 1'b0, gate_inh = 1'b0, exc2 = 1'b0;
    logic add_ins = 1'b0, idx_class = 1'b0, idx_op = 1'b0, alt = 1'b0;
    logic defer = 1'b0, defer_set = 1'b0, exec = 1'b0, half_acc = 1'b0;
    logic halt_inh = 1'b0, set_cc = 1'b0;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2 i_mclk = ~i_mclk;

    core_mem_model mem_u (.i_mclk(i_mclk), .i_start(start), .i_slow(slow),
        .i_word(word), .o_strobe(strobe), .o_done(done), .o_data(mdata));

    idx_add_seq dut_u (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_mem_data(mdata),
        .i_memory_read_strobe(strobe),
        .i_mem_done(done),
        .i_memory_enable(mem_en),
        .i_interrupt_cycle_flag(inter),
        .i_memory_gate_inhibit(gate_inh),
        .i_second_execute_state(exc2),
        .i_indexed_add_instruction(add_ins),
        .i_index_class(idx_class),
        .i_index_op(idx_op),
        .i_alt_mode(alt),
        .i_defer_flag(defer),
        .i_defer_set(defer_set),
        .i_execute_flag(exec),
        .i_half_word_access(half_acc),
        .i_halt_inhibit(halt_inh),
        .i_set_cycle_complete(set_cc),
        .o_start_memory(start),
        .o_memory_address_register(ma),
        .o_memory_buffer(mb),
        .o_accumulator(ac),
        .o_register_bus(rbus),
        .o_overflow(ovf),
        .o_half_word(half),
        .o_run(run),
        .o_memory_idle(idle),
        .o_cycle_complete(cc),
        .o_time_state(ts),
        .o_accumulator_add_control(add_ctl)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            $display("run cut short after %0d cycles", cycles);
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick

    task automatic do_reset();
        i_rstn = 1'b0;
        tick(8);
        check("reset_state", {7'h00, ts}, 12'h001);
        check("reset_flags", {9'h000, run, idle, cc}, 12'h007);
        check("reset_acc", ac, 12'h000);
        i_rstn = 1'b1;
    endtask : do_reset

    // counts how long the sequencer stays in one time state
    task automatic dwell(input logic [4:0] st, input int exp);
        int n;
        n = 0;
        while (ts !== st && n < 600) begin
            tick(1);
            n++;
        end
        n = 0;
        while (ts === st && n < 600) begin
            tick(1);
            n++;
        end
        check("dwell", 12'(n), 12'(exp));
    endtask : dwell

    // one full ts1 to ts1 round with a memory access
    task automatic cycle(input logic [11:0] exp_ma);
        int g;
        g = 0;
        while (start !== 1'b1 && g < 400) begin
            tick(1);
            g++;
        end
        check("start_memory", {11'h000, start}, 12'h001);
        check("ts_after_tp1", {7'h00, ts}, 12'h002);
        check("address", ma, exp_ma);
        check("bus_at_tp1", rbus, exp_ma);
        tick(1);
        check("start_width", {11'h000, start}, 12'h000);
        dwell(5'h04, 88);
        check("idle_cleared", {11'h000, idle}, 12'h000);
        dwell(5'h08, 75);
        dwell(5'h10, 100);
        check("back_to_ts1", {7'h00, ts}, 12'h001);
        check("idle_set", {11'h000, idle}, 12'h001);
    endtask : cycle

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defer();
        {defer, idx_class, idx_op, alt} = 4'hf;
        word = 12'h17f;
        cycle(12'h000);
        check("mb_incr", mb, 12'h180);
        check("half_clear", {11'h000, half}, 12'h000);
        half_acc = 1'b1;
        word = 12'hfff;
        cycle(12'h180);
        check("mb_no_carry", mb, 12'hfff);
        check("half_set", {11'h000, half}, 12'h001);
        check("run_kept", {11'h000, run}, 12'h001);
        $display("test defer done");
    endtask : t_defer

    task automatic t_add();
        {defer, idx_class, idx_op, alt, half_acc} = 5'h00;
        {defer_set, exec, add_ins} = 3'h7;
        word = 12'h801;
        cycle(12'h07f);
        check("add_ctl", {11'h000, add_ctl}, 12'h001);
        check("acc_sum", ac, 12'h801);
        check("no_ovf", {11'h000, ovf}, 12'h000);
        defer_set = 1'b0;
        cycle(12'h000);
        check("acc_wrap", ac, 12'h002);
        check("ovf_set", {11'h000, ovf}, 12'h001);
        $display("test add done");
    endtask : t_add

    task automatic t_gate();
        {exec, add_ins, exc2, slow} = 4'h3;
        word = 12'h0aa;
        cycle(12'h000);
        check("mb_held", mb, 12'h801);
        check("acc_held", ac, 12'h002);
        check("add_off", {11'h000, add_ctl}, 12'h000);
        {exc2, inter} = 2'h1;
        cycle(12'h000);
        check("mb_inter", mb, 12'h000);
        inter = 1'b0;
        cycle(12'h000);
        check("mb_gated", mb, 12'h0aa);
        gate_inh = 1'b1;
        cycle(12'h000);
        check("mb_inhibit", mb, 12'h000);
        $display("test gate done");
    endtask : t_gate

    task automatic t_halt();
        {gate_inh, slow, halt_inh, set_cc} = 4'h3;
        cycle(12'h000);
        check("run_cleared", {11'h000, run}, 12'h000);
        check("cc_set", {11'h000, cc}, 12'h001);
        set_cc = 1'b0;
        tick(50);
        check("held_in_ts1", {7'h00, ts}, 12'h001);
        $display("test halt done");
    endtask : t_halt

    task automatic t_mem_off();
        logic seen;
        seen = 1'b0;
        do_reset();
        {halt_inh, mem_en} = 2'h0;
        repeat (200) begin
            tick(1);
            if (start === 1'b1) begin
                seen = 1'b1;
            end
        end
        check("no_start", {11'h000, seen}, 12'h000);
        check("waits_ts2", {7'h00, ts}, 12'h002);
        check("idle_kept", {11'h000, idle}, 12'h001);
        $display("test memory off done");
    endtask : t_mem_off

    initial begin
        do_reset();
        t_defer();
        t_add();
        t_gate();
        t_halt();
        t_mem_off();
        finish_test();
    end
endmodule : idx_add_seq_tb
`default_nettype wire
